// [shared/pdh_pkg.sv]
// Constants, field layouts and carrier types of the host packet framer.
// Assumes one clock domain; link pins are synchronised inside the framer.
package pdh_pkg;
	// Register byte offsets
	localparam logic [3:0] PDH_OFS_CTRL = 4'h0;
	localparam logic [3:0] PDH_OFS_STAT = 4'h4;
	// Control bits
	localparam int PDH_CTRL_EN   = 0;
	localparam int PDH_CTRL_CKSM = 1;
	localparam int PDH_CTRL_TIME = 2;
	localparam int PDH_CTRL_ALL  = 3;
	localparam int PDH_CTRL_MCOL = 4;
	// Status bits; the fill count sits in bits 5:0
	localparam int PDH_STAT_OVF  = 8;
	localparam int PDH_STAT_STOP = 9;
	localparam int PDH_STAT_RUN  = 10;
	// Buffer shape and link bit count
	localparam logic [5:0] PDH_BUF_DEPTH = 6'h20;
	localparam logic [4:0] PDH_BIT_LAST  = 5'h1f;
	// Packet identifiers and error limits
	localparam logic [7:0] PDH_ID_BIW    = 8'h00;
	localparam logic [7:0] PDH_ID_ADR    = 8'h01;
	localparam logic [2:0] PDH_ERR_MAX   = 3'h2;
	localparam logic [2:0] PDH_ADR_LIM   = 3'h3;
	// Format field codes
	localparam logic [2:0] PDH_FMT_DATE  = 3'h1;
	localparam logic [2:0] PDH_FMT_TIME  = 3'h2;
	localparam logic [2:0] PDH_FMT_SYS   = 3'h5;
	// Address kinds and index bases
	localparam logic [1:0] PDH_AK_USER   = 2'h0;
	localparam logic [1:0] PDH_AK_TEMP   = 2'h1;
	localparam logic [7:0] PDH_IDX_TEMP  = 8'h80;
	localparam logic [7:0] PDH_IDX_OPER  = 8'h90;

	typedef enum logic [2:0] {
		LK_IDLE  = 3'b001,
		LK_SHIFT = 3'b010,
		LK_HOLD  = 3'b100
	} pdh_link_e;

	typedef enum logic [4:0] {
		SRC_PART = 5'b00001,
		SRC_SHUT = 5'b00010,
		SRC_ROAM = 5'b00100,
		SRC_BUF  = 5'b01000,
		SRC_STAT = 5'b10000
	} pdh_src_e;

	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} pdh_bus_s;

	typedef struct packed {
		logic        valid;
		logic [1:0]  word_idx;  // 0 means word 1 of the phase
		logic [1:0]  phase;
		logic [2:0]  fmt;
		logic [13:0] info;
		logic [2:0]  err_cnt;   // Saturating count of bit errors
		logic        chk_fail;
	} pdh_biw_s;

	typedef struct packed {
		logic        valid;
		logic [2:0]  err_cnt;
		logic        match;     // Matches an enabled address
		logic [1:0]  kind;
		logic [3:0]  num;
		logic [1:0]  phase;
		logic        priority_flag;
		logic        long_flag;
		logic        second_word;
		logic        beep_only_flag;
		logic [6:0]  vector_word_number;
	} pdh_adr_s;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} pdh_word_s;
endpackage

// [logic/pdh_tx_framer.sv]
// Decoder-to-host packet selector, buffer and serial shifter.
// Assumes event inputs come from logic on clk, at most one buffered event
// per cycle, and a link master that holds select high between packets.
`timescale 1ns/1ps
module pdh_tx_framer import pdh_pkg::*; #(
	parameter logic [31:0] PART_ID_WORD = 32'h00a5_0001 // Arbitrary value
) (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// Register port
	input  wire pdh_bus_s    bus_req,
	output logic [31:0]      bus_rdata,
	// Decoder events
	input  wire pdh_biw_s    biw_ev,
	input  wire pdh_adr_s    adr_ev,
	input  wire pdh_word_s   data_ev,
	input  wire pdh_word_s   shut_ev,
	input  wire pdh_word_s   roam_ev,
	input  wire logic [31:0] status_word,
	// Serial link pins
	input  wire logic        spi_sck,
	input  wire logic        spi_cs_n,
	output logic             spi_miso,
	output logic             spi_miso_oe_n,
	// Decoder control
	output logic             decode_run,
	output logic             vector_skip,
	output logic             collapse_apply
);

	typedef struct packed {
		logic [31:0][31:0] mem;
		logic [4:0]        wp;
		logic [4:0]        rp;
		logic [5:0]        cnt;
		pdh_link_e         lk;
		pdh_src_e          src;
		logic              cur_buf;
		logic [31:0]       shreg;
		logic [4:0]        bitcnt;
		logic              miso;
		logic              miso_oe_n;
		logic [2:0]        sck_s;
		logic [2:0]        cs_s;
		logic              shut_pend;
		logic [31:0]       shut_word;
		logic              roam_pend;
		logic [31:0]       roam_word;
		logic [4:0]        ctrl;
		logic              ovf;
		logic              stopped;
		logic              run;
		logic              vskip;
		logic              coll_apply;
		logic [31:0]       rdata;
	} pdh_state_s;

	pdh_state_s q;
	pdh_state_s s;
	logic       push_w;
	logic       pop_w;
	logic       cs_act;
	logic       sck_rise;
	logic       sck_fall;

	// Register address match, used for writes and reads
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		hit = (a == ofs);
	endfunction

	// Information word packet layout
	function automatic logic [31:0] biw_pkt(input pdh_biw_s b, input logic err);
		biw_pkt = {PDH_ID_BIW, err, b.phase, 2'b00, b.fmt, 2'b00, b.info};
	endfunction

	// Address packet layout with index built from kind and address number num
	function automatic logic [31:0] adr_pkt(input pdh_adr_s a);
		logic [7:0] idx;
		logic       beep;
		idx = {4'h0, a.num};
		if (a.kind == PDH_AK_TEMP) begin
			idx = PDH_IDX_TEMP | {4'h0, a.num};
		end else if (a.kind != PDH_AK_USER) begin
			idx = PDH_IDX_OPER | {4'h0, a.num};
		end
		beep = a.beep_only_flag & (a.kind == PDH_AK_USER);
		adr_pkt = {PDH_ID_ADR, a.priority_flag, a.phase, a.long_flag, 4'h0,
			idx, beep, a.vector_word_number};
	endfunction

	assign cs_act   = ~q.cs_s[2];
	assign sck_rise = q.sck_s[1] & ~q.sck_s[2];
	assign sck_fall = ~q.sck_s[1] & q.sck_s[2];

	// Next-state logic for the whole block
	always_comb begin
		logic        err;
		logic        fwd;
		logic        consume;
		logic [31:0] pword;
		logic [31:0] pkt;
		pdh_src_e    sel;
		err     = 1'b0;
		fwd     = 1'b0;
		consume = 1'b0;
		pword   = 32'h0000_0000;
		pkt     = 32'h0000_0000;
		sel     = SRC_STAT;
		push_w  = 1'b0;
		pop_w   = 1'b0;
		s       = q;
		s.vskip = 1'b0;

		// Link pins pass two flops before edge detection
		s.sck_s = {q.sck_s[1:0], spi_sck};
		s.cs_s  = {q.cs_s[1:0], spi_cs_n};

		// Source choice, evaluated only when a transfer opens
		if (!q.ctrl[PDH_CTRL_CKSM]) begin
			sel = SRC_PART;
			pkt = PART_ID_WORD;
		end else if (q.shut_pend) begin
			sel = SRC_SHUT;
			pkt = q.shut_word;
		end else if (q.roam_pend) begin
			sel = SRC_ROAM;
			pkt = q.roam_word;
		end else if (q.cnt != 6'h00) begin
			sel = SRC_BUF;
			pkt = q.mem[q.rp];
		end else begin
			sel = SRC_STAT;
			pkt = status_word;
		end

		// Link shifter; data changes on falling clock, host samples on rising
		case (q.lk)
			LK_IDLE: begin
				if (cs_act) begin
					s.src       = sel;
					s.cur_buf   = (sel == SRC_BUF);
					s.shreg     = pkt;
					s.miso      = pkt[31];
					s.miso_oe_n = 1'b0;
					s.bitcnt    = 5'h00;
					s.lk        = LK_SHIFT;
				end
			end
			LK_SHIFT: begin
				if (!cs_act) begin
					// Aborted packet is not consumed and is chosen again
					s.lk        = LK_IDLE;
					s.miso_oe_n = 1'b1;
				end else if (sck_rise) begin
					if (q.bitcnt == PDH_BIT_LAST) begin
						consume = 1'b1;
						s.lk    = LK_HOLD;
					end else begin
						s.bitcnt = q.bitcnt + 5'h01;
					end
				end else if (sck_fall) begin
					s.shreg = {q.shreg[30:0], 1'b0};
					s.miso  = q.shreg[30];
				end
			end
			LK_HOLD: begin
				if (!cs_act) begin
					s.lk        = LK_IDLE;
					s.miso_oe_n = 1'b1;
				end
			end
			default: begin
				s.lk        = LK_IDLE;
				s.miso_oe_n = 1'b1;
			end
		endcase

		// Pending words leave as their transfer opens and return on an abort,
		// so a newer word that lands mid-transfer is still sent afterwards
		if (q.lk == LK_IDLE && cs_act && sel == SRC_SHUT) begin
			s.shut_pend = 1'b0;
		end
		if (q.lk == LK_SHIFT && !cs_act && q.src == SRC_SHUT) begin
			s.shut_pend = 1'b1;
		end
		if (q.lk == LK_IDLE && cs_act && sel == SRC_ROAM) begin
			s.roam_pend = 1'b0;
		end
		if (q.lk == LK_SHIFT && !cs_act && q.src == SRC_ROAM) begin
			s.roam_pend = 1'b1;
		end
		// A new event in the same cycle wins
		if (shut_ev.valid) begin
			s.shut_pend = 1'b1;
			s.shut_word = shut_ev.data;
		end
		if (roam_ev.valid) begin
			s.roam_pend = 1'b1;
			s.roam_word = roam_ev.data;
		end

		// Information word filter
		if (biw_ev.valid && q.run) begin
			err = (biw_ev.err_cnt > PDH_ERR_MAX) | biw_ev.chk_fail;
			if (biw_ev.word_idx == 2'h0) begin
				fwd = q.ctrl[PDH_CTRL_MCOL];
			end else begin
				fwd = q.ctrl[PDH_CTRL_ALL]
					| (err & q.ctrl[PDH_CTRL_TIME])
					| (q.ctrl[PDH_CTRL_TIME] & (biw_ev.fmt == PDH_FMT_DATE
					| biw_ev.fmt == PDH_FMT_TIME | biw_ev.fmt == PDH_FMT_SYS));
				s.vskip = (biw_ev.fmt == PDH_FMT_SYS);
			end
			push_w = fwd;
			pword  = biw_pkt(biw_ev, err);
		end else if (adr_ev.valid && q.run) begin
			// Long addresses report once, on their second word
			push_w = (adr_ev.err_cnt < PDH_ADR_LIM) & adr_ev.match
				& (~adr_ev.long_flag | adr_ev.second_word);
			pword  = adr_pkt(adr_ev);
		end else if (data_ev.valid && q.run) begin
			push_w = 1'b1;
			pword  = data_ev.data;
		end

		// Transmit buffer; pop only if the packet came from this buffer fill
		pop_w = consume & (q.src == SRC_BUF) & q.cur_buf & (q.cnt != 6'h00);
		if (pop_w) begin
			s.rp = q.rp + 5'h01;
		end
		if (push_w && q.cnt == PDH_BUF_DEPTH && !pop_w) begin
			// Overflow drops the whole queue rather than guess what to keep
			s.wp      = 5'h00;
			s.rp      = 5'h00;
			s.cnt     = 6'h00;
			s.cur_buf = 1'b0;
			s.stopped = 1'b1;
			s.ovf     = 1'b1;
		end else begin
			if (push_w) begin
				s.mem[q.wp] = pword;
				s.wp        = q.wp + 5'h01;
			end
			s.cnt = q.cnt + {5'h00, push_w} - {5'h00, pop_w};
		end

		// Register writes; hardware set of overflow wins over the clear
		if (bus_req.wr && hit(bus_req.addr, PDH_OFS_CTRL)) begin
			s.ctrl = bus_req.wdata[4:0];
			if (bus_req.wdata[PDH_CTRL_EN]) begin
				s.stopped = s.stopped & ~(q.cnt != PDH_BUF_DEPTH | ~push_w);
			end
		end
		if (bus_req.wr && hit(bus_req.addr, PDH_OFS_STAT)
			&& bus_req.wdata[PDH_STAT_OVF] && !s.ovf) begin
			s.ovf = 1'b0;
		end else if (bus_req.wr && hit(bus_req.addr, PDH_OFS_STAT)
			&& bus_req.wdata[PDH_STAT_OVF] && q.ovf && !(push_w
			&& q.cnt == PDH_BUF_DEPTH && !pop_w)) begin
			s.ovf = 1'b0;
		end

		// Register reads answer in the next cycle only
		s.rdata = 32'h0000_0000;
		if (bus_req.rd && hit(bus_req.addr, PDH_OFS_CTRL)) begin
			s.rdata = {27'h0000000, q.ctrl};
		end else if (bus_req.rd && hit(bus_req.addr, PDH_OFS_STAT)) begin
			s.rdata = {21'h000000, q.run, q.stopped, q.ovf, 2'h0, q.cnt};
		end

		// Decoder control outputs
		s.run        = s.ctrl[PDH_CTRL_EN] & s.ctrl[PDH_CTRL_CKSM] & ~s.stopped;
		s.coll_apply = ~s.ctrl[PDH_CTRL_MCOL];
	end

	// State register
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			q            <= '0;
			q.lk         <= LK_IDLE;
			q.src        <= SRC_STAT;
			q.miso_oe_n  <= 1'b1;
			q.cs_s       <= 3'h7;
			q.coll_apply <= 1'b1;
		end else begin
			q <= s;
		end
	end

	// Outputs come straight from the state register
	assign bus_rdata      = q.rdata;
	assign spi_miso       = q.miso;
	assign spi_miso_oe_n  = q.miso_oe_n;
	assign decode_run     = q.run;
	assign vector_skip    = q.vskip;
	assign collapse_apply = q.coll_apply;

	// Checks on packet choice and buffer behaviour
	chk_part_only: assert property (@(posedge clk) disable iff (sys_rst)
		(q.lk == LK_IDLE && cs_act && !q.ctrl[PDH_CTRL_CKSM]) |=> q.src == SRC_PART)
		else $error("part identity not chosen while protected");

	chk_shut_first: assert property (@(posedge clk) disable iff (sys_rst)
		(q.lk == LK_IDLE && cs_act && q.ctrl[PDH_CTRL_CKSM] && q.shut_pend)
		|=> q.src == SRC_SHUT)
		else $error("pending shutdown not sent first");

	chk_roam_next: assert property (@(posedge clk) disable iff (sys_rst)
		(q.lk == LK_IDLE && cs_act && q.ctrl[PDH_CTRL_CKSM] && !q.shut_pend
		&& q.roam_pend) |=> q.src == SRC_ROAM)
		else $error("pending roaming status not sent second");

	chk_buf_stat: assert property (@(posedge clk) disable iff (sys_rst)
		(q.lk == LK_IDLE && cs_act && q.ctrl[PDH_CTRL_CKSM] && !q.shut_pend
		&& !q.roam_pend) |=> q.src == (($past(q.cnt) != 6'h00) ? SRC_BUF : SRC_STAT))
		else $error("buffer or status choice wrong");

	chk_msb_first: assert property (@(posedge clk) disable iff (sys_rst)
		(q.lk == LK_SHIFT && cs_act && sck_fall) |=> q.miso == $past(q.shreg[30]))
		else $error("serial bit order wrong");

	chk_pkt_stable: assert property (@(posedge clk) disable iff (sys_rst)
		(q.lk == LK_SHIFT) |=> (q.lk != LK_SHIFT || $stable(q.src)))
		else $error("packet source changed mid transfer");

	chk_ovf_clear: assert property (@(posedge clk) disable iff (sys_rst)
		(push_w && q.cnt == PDH_BUF_DEPTH && !pop_w)
		|=> (q.cnt == 6'h00 && q.stopped && !decode_run) ##1 !decode_run)
		else $error("overflow did not flush and stop");

	chk_adr_drop: assert property (@(posedge clk) disable iff (sys_rst)
		(adr_ev.valid && adr_ev.err_cnt >= PDH_ADR_LIM && !biw_ev.valid)
		|=> q.cnt <= $past(q.cnt))
		else $error("errored address was buffered");

	chk_sys_skip: assert property (@(posedge clk) disable iff (sys_rst)
		(biw_ev.valid && q.run && biw_ev.word_idx != 2'h0 && biw_ev.fmt == PDH_FMT_SYS)
		|=> vector_skip)
		else $error("system message did not skip vectors");

	chk_word1_held: assert property (@(posedge clk) disable iff (sys_rst)
		(biw_ev.valid && q.run && biw_ev.word_idx == 2'h0 && !q.ctrl[PDH_CTRL_MCOL])
		|=> q.cnt <= $past(q.cnt))
		else $error("first info word was buffered");

	chk_err_fwd: assert property (@(posedge clk) disable iff (sys_rst)
		(biw_ev.valid && q.run && biw_ev.word_idx != 2'h0 && biw_ev.chk_fail
		&& q.ctrl[PDH_CTRL_TIME]) |-> push_w)
		else $error("uncorrectable info word not forwarded");

	chk_long_once: assert property (@(posedge clk) disable iff (sys_rst)
		(adr_ev.valid && !biw_ev.valid && adr_ev.long_flag && !adr_ev.second_word)
		|=> q.cnt <= $past(q.cnt))
		else $error("first word of long address was buffered");
endmodule

// [tb/pdh_spi_host.sv]
// Host side of the serial link: a mode 0 master that reads packets.
// Assumes clk is the framer clock; sck half period is 8 clk (80 ns).
`timescale 1ns/1ps
module pdh_spi_host (
	// Clock
	input  wire logic clk,
	// Link pins
	input  wire logic miso,
	input  wire logic miso_oe_n,
	output logic      sck,
	output logic      cs_n
);
	logic last_q;
	logic line;

	// Link idles with select high and clock low, as the framer expects
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		last_q = 1'b0;
	end
	// A released line shows the inverse of its last level, never a lucky copy
	always @(posedge clk) if (!miso_oe_n) last_q <= miso;
	assign line = miso_oe_n ? ~last_q : miso;

	// Read nbits bits MSB first; fewer than 32 aborts the transfer
	task automatic xfer(output logic [31:0] w, input int nbits);
		w = '0;
		@(posedge clk) cs_n <= 1'b0;
		repeat (8) @(posedge clk);
		for (int i = 0; i < nbits; i++) begin
			@(posedge clk) sck <= 1'b1;
			w = {w[30:0], line};
			repeat (8) @(posedge clk);
			sck <= 1'b0;
			repeat (7) @(posedge clk);
		end
		@(posedge clk) cs_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask
endmodule

// [tb/test_pdh_tx_framer.sv]
// Self-checking bench of the host packet framer, read by a serial host model.
// Assumes registered framer outputs and a 100 MHz clock.
`timescale 1ns/1ps
module test_pdh_tx_framer import pdh_pkg::*; ;
	localparam logic [31:0] PID = 32'h0c3e_97a1; // Arbitrary value
	localparam logic [31:0] STW = 32'h5a5a_0f0f;
	localparam logic [31:0] BM = 32'hffe7_3fff;
	localparam logic [31:0] AM = 32'hfff0_ffff;
	logic        clk;
	logic        sys_rst;
	pdh_bus_s    bus_req;
	logic [31:0] bus_rdata;
	pdh_biw_s    biw_ev;
	pdh_adr_s    adr_ev;
	pdh_word_s   data_ev;
	pdh_word_s   shut_ev;
	pdh_word_s   roam_ev;
	logic        spi_sck;
	logic        spi_cs_n;
	logic        spi_miso;
	logic        spi_miso_oe_n;
	logic        decode_run;
	logic        vector_skip;
	logic        collapse_apply;
	int          bad_count = 0;
	int          cmp_count = 0;
	int          skip_cnt = 0;
	logic [31:0] w;
	logic [31:0] stat_word;

	pdh_tx_framer #(.PART_ID_WORD(PID)) u_pdh_tx_framer (.clk(clk), .sys_rst(sys_rst),
		.bus_req(bus_req), .bus_rdata(bus_rdata), .biw_ev(biw_ev), .adr_ev(adr_ev),
		.data_ev(data_ev), .shut_ev(shut_ev), .roam_ev(roam_ev), .status_word(stat_word),
		.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_miso(spi_miso),
		.spi_miso_oe_n(spi_miso_oe_n), .decode_run(decode_run),
		.vector_skip(vector_skip), .collapse_apply(collapse_apply));
	pdh_spi_host u_pdh_spi_host (.clk(clk), .miso(spi_miso), .miso_oe_n(spi_miso_oe_n),
		.sck(spi_sck), .cs_n(spi_cs_n));

	// Clock and skip pulse counter
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk) if (vector_skip === 1'b1) skip_cnt++;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	// Register port cycles: strobes last one cycle, read data in the next
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk) bus_req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk) bus_req <= '0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
		@(posedge clk) bus_req <= '0;
		#1 d = bus_rdata;
	endtask
	task automatic pk(input string n, input logic [31:0] e, input logic [31:0] m);
		u_pdh_spi_host.xfer(w, 32);
		chk(n, e & m, w & m);
	endtask
	// Event pulses: k 0 data, 1 shutdown, 2 roaming
	task automatic ev(input int k, input logic [31:0] d);
		@(posedge clk) begin
			data_ev <= '{k == 0, d};
			shut_ev <= '{k == 1, d};
			roam_ev <= '{k == 2, d};
		end
		@(posedge clk) {data_ev, shut_ev, roam_ev} <= '0;
	endtask
	task automatic bw(input int i, input int f, input logic [2:0] ec, input logic cf);
		@(posedge clk) biw_ev <= '{1'b1, 2'(i), 2'(f), 3'(f), {11'h2a5, 3'(f)}, ec, cf};
		@(posedge clk) biw_ev <= '0;
	endtask
	function automatic logic [31:0] bp(input int f, input logic e);
		return {8'h00, e, 2'(f), 2'b00, 3'(f), 2'b00, 11'h2a5, 3'(f)};
	endfunction
	task automatic ad(input int ec, m, k, n, ph, p, l, s, b, wn);
		@(posedge clk) adr_ev <= '{1'b1, 3'(ec), 1'(m), 2'(k), 4'(n), 2'(ph), 1'(p), 1'(l),
			1'(s), 1'(b), 7'(wn)};
		@(posedge clk) adr_ev <= '0;
	endtask
	function automatic logic [31:0] ap(input int p, ph, l, ix, b, wn);
		return {8'h01, 1'(p), 2'(ph), 1'(l), 4'h0, 8'(ix), 1'(b), 7'(wn)};
	endfunction

	task automatic t_rst();
		chk("oe_n", 32'h1, {31'h0, spi_miso_oe_n});
		chk("coll", 32'h1, {31'h0, collapse_apply});
		rd(PDH_OFS_CTRL, w);
		chk("ctrl", 32'h0, w);
		wr(4'h8, 32'hffff_ffff);
		rd(4'h8, w);
		chk("unmapped", 32'h0, w);
		pk("pid", PID, '1);
		// Everything enabled except the checksum confirmation
		wr(PDH_OFS_CTRL, 32'h1d);
		ev(0, 32'h0bad_0000);
		pk("pid2", PID, '1);
		chk("run0", 32'h0, {31'h0, decode_run});
		$display("test reset done");
	endtask
	task automatic t_prio();
		wr(PDH_OFS_CTRL, 32'h03);
		repeat (2) @(posedge clk);
		ev(0, 32'hd0d0_0001);
		ev(0, 32'hd0d0_0002);
		ev(2, 32'h7070_0003);
		ev(1, 32'h5151_0004);
		rd(PDH_OFS_STAT, w);
		chk("count", 32'h402, w);
		pk("shut", 32'h5151_0004, '1);
		pk("roam", 32'h7070_0003, '1);
		pk("d1", 32'hd0d0_0001, '1);
		pk("d2", 32'hd0d0_0002, '1);
		pk("stat", STW, '1);
		@(posedge clk) stat_word <= ~STW;
		pk("stat2", ~STW, '1);
		@(posedge clk) stat_word <= STW;
		$display("test priority done");
	endtask
	// A shutdown word that arrives while an earlier one is shifting out
	task automatic t_late();
		ev(1, 32'h5151_0005);
		fork
			pk("shut1", 32'h5151_0005, '1);
			begin
				repeat (100) @(posedge clk);
				ev(1, 32'h5151_0006);
			end
		join
		pk("shut2", 32'h5151_0006, '1);
		pk("stat3", STW, '1);
		$display("test late shutdown done");
	endtask
	task automatic t_biw();
		int k;
		logic fw;
		for (int s = 0; s < 2; s++) begin
			wr(PDH_OFS_CTRL, s ? 32'h0b : 32'h07);
			for (int f = 0; f < 8; f++) begin
				k = skip_cnt;
				fw = s == 1 || f == 1 || f == 2 || f == 5;
				bw(1 + f % 3, f, 3'h0, 1'b0);
				repeat (3) @(posedge clk);
				chk("skip", k + (f == 5), skip_cnt);
				pk("biw", fw ? bp(f, 1'b0) : STW, fw ? BM : '1);
			end
		end
		wr(PDH_OFS_CTRL, 32'h07);
		bw(2, 0, 3'h3, 1'b0);
		pk("err3", bp(0, 1'b1), BM);
		bw(3, 3, 3'h0, 1'b1);
		pk("chkf", bp(3, 1'b1), BM);
		bw(2, 0, 3'h2, 1'b0);
		pk("err2", STW, '1);
		bw(0, 5, 3'h0, 1'b0);
		pk("word1", STW, '1);
		wr(PDH_OFS_CTRL, 32'h17);
		bw(0, 5, 3'h0, 1'b0);
		pk("collapse", {18'h0, 11'h2a5, 3'h5}, 32'hff00_3fff);
		chk("coll", 32'h0, {31'h0, collapse_apply});
		$display("test info words done");
	endtask
	task automatic t_adr();
		wr(PDH_OFS_CTRL, 32'h03);
		ad(2, 1, 0, 5, 2, 1, 0, 0, 0, 87);
		ad(3, 1, 0, 9, 0, 0, 0, 0, 0, 10);
		ad(0, 0, 0, 9, 0, 0, 0, 0, 0, 10);
		ad(0, 1, 1, 3, 1, 0, 0, 0, 1, 2);
		ad(0, 1, 2, 15, 3, 0, 0, 0, 0, 40);
		ad(0, 1, 3, 0, 0, 0, 0, 0, 0, 3);
		ad(0, 1, 0, 6, 0, 0, 1, 0, 0, 20);
		ad(0, 1, 0, 7, 0, 0, 1, 1, 1, 20);
		pk("user", ap(1, 2, 0, 5, 0, 87), AM);
		pk("temp", ap(0, 1, 0, 131, 0, 2), AM);
		pk("oper", ap(0, 3, 0, 159, 0, 40), AM);
		pk("oper0", ap(0, 0, 0, 144, 0, 3), AM);
		pk("long", ap(0, 0, 1, 7, 1, 0), AM & 32'hffff_ff80);
		pk("none", STW, '1);
		$display("test address done");
	endtask
	task automatic t_abort();
		ev(0, 32'hc0ff_ee01);
		u_pdh_spi_host.xfer(w, 10);
		chk("part", 32'h303, w);
		pk("again", 32'hc0ff_ee01, '1);
		chk("oe_off", 32'h1, {31'h0, spi_miso_oe_n});
		$display("test abort done");
	endtask
	task automatic t_ovf();
		for (int i = 0; i < 32; i++) ev(0, 32'(i));
		rd(PDH_OFS_STAT, w);
		chk("full", 32'h420, w);
		pk("oldest", 32'h0, '1);
		ev(0, 32'h1f0);
		ev(0, 32'h1f1);
		rd(PDH_OFS_STAT, w);
		chk("ovf", 32'h300, w);
		chk("run", 32'h0, {31'h0, decode_run});
		pk("drop", STW, '1);
		wr(PDH_OFS_STAT, 32'h7ff);
		rd(PDH_OFS_STAT, w);
		chk("w1c", 32'h200, w);
		wr(PDH_OFS_CTRL, 32'h03);
		rd(PDH_OFS_STAT, w);
		chk("rerun", 32'h400, w);
		$display("test overflow done");
	endtask

	// Main sequence after six reset cycles and an idle link
	initial begin
		sys_rst = 1'b1;
		bus_req = '0;
		biw_ev = '0;
		adr_ev = '0;
		data_ev = '0;
		shut_ev = '0;
		roam_ev = '0;
		stat_word = STW;
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (4) @(posedge clk);
		t_rst();
		t_prio();
		t_late();
		t_biw();
		t_adr();
		t_abort();
		t_ovf();
		final_report();
	end
	// Watchdog well beyond the roughly 22k cycles the tests need
	initial begin
		#600000;
		bad_count++;
		final_report();
	end
endmodule
